// *** verilog/flash_status_pkg.sv ***
// shared constants, enums and carriers for the flash read and status sequencer
package flash_status_pkg;
  // timing
  localparam int CLK_MHZ = 25;
  localparam int PROT_ERASE_US = 100;
  localparam int PROT_ERASE_CYC = PROT_ERASE_US * CLK_MHZ;
  localparam int ERASE_WIN_US = 120; // 100 us plus 20 %
  localparam int ERASE_WIN_CYC = ERASE_WIN_US * CLK_MHZ;
  localparam logic [11:0] PROT_ERASE_LOAD = 12'(PROT_ERASE_CYC);
  localparam logic [11:0] ERASE_WIN_LOAD = 12'(ERASE_WIN_CYC);
  // coded cycles and command bytes
  localparam logic [11:0] CODE_ADDR1 = 12'h555;
  localparam logic [11:0] CODE_ADDR2 = 12'haaa;
  localparam logic [7:0] CODE_DATA1 = 8'haa;
  localparam logic [7:0] CODE_DATA2 = 8'h55;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_READ_IDENT = 8'h90;
  localparam logic [7:0] CMD_FLASH_RESET = 8'hf0;
  localparam logic [7:0] CMD_OTP_READ = 8'h88;
  localparam logic [7:0] CMD_EE_RETURN = 8'h98;
  // special read addresses on bits 6,1,0
  localparam logic [2:0] SEL_IDENT = 3'b001;
  localparam logic [2:0] SEL_PROTECT = 3'b010;
  localparam logic [7:0] PROT_YES = 8'h01;
  localparam logic [7:0] PROT_NO = 8'h00;
  // status byte bit positions
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int ERROR_BIT = 5;
  localparam int WINDOW_BIT = 3;
  // register map
  localparam logic [7:0] OFS_FLASH_PROT = 8'h00;
  localparam logic [7:0] OFS_EE_PROT = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] FLASH_PROT_RST = 8'h00;
  localparam logic [3:0] EE_PROT_RST = 4'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

  typedef enum logic [1:0] {
    mode_array = 2'b00,
    mode_ident = 2'b01,
    mode_otp = 2'b10
  } read_mode_e;

  typedef enum logic [2:0] {
    seq_idle = 3'b000,
    seq_code1 = 3'b001,
    seq_cmd = 3'b010,
    seq_erase1 = 3'b011,
    seq_erase2 = 3'b100,
    seq_erase3 = 3'b101,
    seq_prog = 3'b110
  } seq_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr_n;
    logic rd_n;
    logic [7:0] fsel;
    logic [3:0] esel;
  } mcu_pins_s;

  typedef struct packed {
    logic prog;
    logic erase;
    logic ee_write;
    logic [15:0] addr;
    logic [7:0] data;
  } op_req_s;
endpackage : flash_status_pkg

// *** verilog/flash_status_seq.sv ***
// read path, instruction decode and status byte of the flash and eeprom controller
//
// Local design decisions: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module flash_status_seq
  import flash_status_pkg::*;
#(
  parameter logic [7:0] FLASH_IDENT = 8'h5a // value is arbitrary
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire mcu_pins_s mcu_in,
  output logic [7:0] mcu_rdata,
  output logic mcu_rdata_oe,
  output logic [15:0] mem_addr,
  output logic mem_otp,
  input wire logic [7:0] mem_rdata,
  output op_req_s op_req,
  input wire logic prog_busy,
  input wire logic erase_busy,
  input wire logic ee_busy,
  input wire logic busy_data7,
  input wire logic op_fail
);
  mcu_pins_s sync1, sync2, sync3, pins, pins_prev;
  read_mode_e mode;
  seq_e seq;
  logic [7:0] flash_prot;
  logic [3:0] ee_prot;
  logic [11:0] prot_cnt;
  logic [11:0] win_cnt;
  logic error_flag;
  logic toggle;
  logic win_open;
  logic ahb_wr, ahb_rd;
  logic [7:0] ahb_ofs;
  logic [7:0] next_rdata;

  // pin synchroniser, a change counts once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= '{default: '1, fsel: '0, esel: '0, addr: '0, wdata: '0};
      sync2 <= '{default: '1, fsel: '0, esel: '0, addr: '0, wdata: '0};
      sync3 <= '{default: '1, fsel: '0, esel: '0, addr: '0, wdata: '0};
    end else begin
      sync1 <= mcu_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins <= '{default: '1, fsel: '0, esel: '0, addr: '0, wdata: '0};
      pins_prev <= '{default: '1, fsel: '0, esel: '0, addr: '0, wdata: '0};
    end else begin
      if (sync2 == sync3) begin
        pins <= sync3;
      end
      pins_prev <= pins;
    end
  end

  wire wr_fall = pins_prev.wr_n && !pins.wr_n;
  wire rd_fall = pins_prev.rd_n && !pins.rd_n;
  wire fsel_any = |pins.fsel;
  wire esel_any = |pins.esel;
  wire sel_prot = |(pins.fsel & flash_prot);
  wire is_code1 = pins.addr[11:0] == CODE_ADDR1 && pins.wdata == CODE_DATA1;
  wire is_code2 = pins.addr[11:0] == CODE_ADDR2 && pins.wdata == CODE_DATA2;
  wire cmd_at_555 = pins.addr[11:0] == CODE_ADDR1;
  wire sector_erase = wr_fall && fsel_any && seq == seq_erase3 &&
                      pins.wdata == CMD_SECTOR_ERASE;
  wire flash_reset = wr_fall && seq == seq_cmd && cmd_at_555 &&
                     pins.wdata == CMD_FLASH_RESET;
  wire ee_return = wr_fall && seq == seq_cmd && cmd_at_555 && pins.wdata == CMD_EE_RETURN;
  wire flash_busy = prog_busy || erase_busy || prot_cnt != 12'h000;
  wire any_busy = flash_busy || ee_busy;
  wire [2:0] special = {pins.addr[6], pins.addr[1], pins.addr[0]};

  // command decoder, a wrong byte drops back to the idle step
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq <= seq_idle;
    end else if (wr_fall && (fsel_any || esel_any)) begin
      case (seq)
        seq_idle: seq <= is_code1 ? seq_code1 : seq_idle;
        seq_code1: seq <= is_code2 ? seq_cmd : seq_idle;
        seq_cmd: begin
          if (cmd_at_555 && pins.wdata == CMD_PROGRAM) begin
            seq <= seq_prog;
          end else if (cmd_at_555 && pins.wdata == CMD_ERASE_SETUP) begin
            seq <= seq_erase1;
          end else begin
            seq <= seq_idle;
          end
        end
        seq_erase1: seq <= is_code1 ? seq_erase2 : seq_idle;
        seq_erase2: seq <= is_code2 ? seq_erase3 : seq_idle;
        seq_erase3: seq <= seq_idle;
        seq_prog: seq <= seq_idle;
        default: seq <= seq_idle;
      endcase
    end
  end

  // read mode; identifier and row modes stay until their exit command
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode <= mode_array;
    end else if (wr_fall && seq == seq_cmd && cmd_at_555) begin
      if (pins.wdata == CMD_FLASH_RESET && mode == mode_ident) begin
        mode <= mode_array;
      end else if (pins.wdata == CMD_READ_IDENT && fsel_any && mode == mode_array) begin
        mode <= mode_ident;
      end else if (pins.wdata == CMD_OTP_READ && esel_any && mode == mode_array) begin
        mode <= mode_otp;
      end else if (pins.wdata == CMD_EE_RETURN && mode == mode_otp) begin
        mode <= mode_array;
      end
    end
  end

  // requests to the program engine; protected flash targets never start, eeprom writes ignore ee_prot
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_req <= '0;
    end else begin
      op_req.prog <= wr_fall && seq == seq_prog && fsel_any && !sel_prot;
      op_req.erase <= sector_erase && !sel_prot;
      op_req.ee_write <= wr_fall && esel_any && seq == seq_idle && !is_code1;
      if (wr_fall) begin
        op_req.addr <= pins.addr;
        op_req.data <= pins.wdata;
      end
    end
  end

  // erase naming any protected sector, no erase running: pretend to be busy for a while
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prot_cnt <= 12'h000;
    end else if (sector_erase && sel_prot && !erase_busy) begin
      prot_cnt <= PROT_ERASE_LOAD;
    end else if (prot_cnt != 12'h000) begin
      prot_cnt <= prot_cnt - 12'h001;
    end
  end

  // erase window, closed early by a second sector erase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      win_open <= 1'b0;
      win_cnt <= 12'h000;
    end else if (sector_erase && !win_open) begin
      win_open <= 1'b1;
      win_cnt <= ERASE_WIN_LOAD;
    end else if (sector_erase || win_cnt == 12'h001) begin
      win_open <= 1'b0;
      win_cnt <= 12'h000;
    end else if (win_cnt != 12'h000) begin
      win_cnt <= win_cnt - 12'h001;
    end
  end

  // error flag, a failure in the clearing cycle still sets it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      error_flag <= 1'b0;
    end else if (op_fail) begin
      error_flag <= 1'b1;
    end else if (flash_reset) begin
      error_flag <= 1'b0;
    end
  end

  // toggle flips on each selected read while any engine is busy; reads never touch the engine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      toggle <= 1'b0;
    end else if (rd_fall && any_busy && (fsel_any || esel_any)) begin
      toggle <= !toggle;
    end
  end

  // read data selection
  always_comb begin
    next_rdata = mem_rdata;
    if (fsel_any && flash_busy) begin
      next_rdata = 8'h00;
      next_rdata[POLL_BIT] = prog_busy && !erase_busy && prot_cnt == 12'h000 &&
                             !busy_data7;
      next_rdata[TOGGLE_BIT] = toggle;
      next_rdata[ERROR_BIT] = error_flag;
      next_rdata[WINDOW_BIT] = !win_open;
    end else if (esel_any && ee_busy) begin
      next_rdata = 8'h00;
      next_rdata[POLL_BIT] = !busy_data7;
      next_rdata[TOGGLE_BIT] = toggle;
    end else if (mode == mode_ident && fsel_any && special == SEL_IDENT) begin
      next_rdata = FLASH_IDENT;
    end else if (mode == mode_ident && fsel_any && special == SEL_PROTECT) begin
      next_rdata = sel_prot ? PROT_YES : PROT_NO;
    end
  end

  // the array sees the live address; row reads address the row
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mcu_rdata <= 8'h00;
      mcu_rdata_oe <= 1'b0;
      mem_addr <= 16'h0000;
      mem_otp <= 1'b0;
    end else begin
      mem_addr <= pins.addr;
      mem_otp <= mode == mode_otp && esel_any && !pins.addr[6];
      mcu_rdata_oe <= !pins.rd_n && (fsel_any || esel_any);
      if (rd_fall) begin
        mcu_rdata <= next_rdata;
      end
    end
  end

  // ahb-lite slave, zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ahb_wr <= 1'b0;
      ahb_rd <= 1'b0;
      ahb_ofs <= 8'h00;
    end else if (hready) begin
      ahb_wr <= hsel && htrans == HTRANS_NONSEQ && hwrite;
      ahb_rd <= hsel && htrans == HTRANS_NONSEQ && !hwrite;
      ahb_ofs <= haddr[7:0];
    end
  end

  // protection masks, written by software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flash_prot <= FLASH_PROT_RST;
      ee_prot <= EE_PROT_RST;
    end else if (ahb_wr) begin
      if (ahb_ofs == OFS_FLASH_PROT) begin
        flash_prot <= hwdata[7:0];
      end else if (ahb_ofs == OFS_EE_PROT) begin
        ee_prot <= hwdata[3:0];
      end
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    hrdata = 32'h0000_0000;
    if (!ahb_rd) begin
      hrdata = 32'h0000_0000;
    end else if (ahb_ofs == OFS_FLASH_PROT) begin
      hrdata = {24'h000000, flash_prot};
    end else if (ahb_ofs == OFS_EE_PROT) begin
      hrdata = {28'h0000000, ee_prot};
    end else if (ahb_ofs == OFS_STATUS) begin
      hrdata = {24'h000000, any_busy, win_open, error_flag, seq, mode};
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // checks on the decoder, the flags and the read path
  // the second coded cycle must follow the first with nothing in between
  sequence s_code_pair;
    wr_fall && seq == seq_idle && is_code1 && fsel_any ##[1:300]
      wr_fall && seq == seq_code1 && is_code2 && fsel_any;
  endsequence

  a_error_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    flash_reset && !op_fail |=> !error_flag) else $error("error bit not cleared");
  a_error_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    error_flag && !flash_reset |=> error_flag) else $error("error bit lost");
  a_error_set: assert property (@(posedge hclk) disable iff (!hresetn)
    op_fail |=> error_flag) else $error("error bit not set");
  a_prot_prog: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_fall && seq == seq_prog && sel_prot |=> !op_req.prog) else $error("protected program");
  a_prot_erase: assert property (@(posedge hclk) disable iff (!hresetn)
    sector_erase && sel_prot && !erase_busy |=> flash_busy [*8]) else $error("no fake erase");
  a_window_close: assert property (@(posedge hclk) disable iff (!hresetn)
    sector_erase && win_open |=> !win_open) else $error("window stayed open");
  a_window_open: assert property (@(posedge hclk) disable iff (!hresetn)
    sector_erase && !win_open |=> win_open && win_cnt == ERASE_WIN_LOAD) else $error("window");
  a_code_pair: assert property (@(posedge hclk) disable iff (!hresetn)
    s_code_pair |=> seq == seq_cmd) else $error("coded cycles not decoded");
  a_toggle_read: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_fall && any_busy && fsel_any |=> toggle != $past(toggle)) else $error("no toggle");
  a_toggle_still: assert property (@(posedge hclk) disable iff (!hresetn)
    !any_busy |=> toggle == $past(toggle)) else $error("toggle while idle");
  a_ident_stays: assert property (@(posedge hclk) disable iff (!hresetn)
    mode == mode_ident && !flash_reset |=> mode == mode_ident) else $error("ident left");
  a_prog_start: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_fall && seq == seq_prog && fsel_any && !sel_prot |=> op_req.prog)
    else $error("program request missing");
  a_erase_poll: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_fall && fsel_any && erase_busy |=> !mcu_rdata[POLL_BIT]) else $error("poll not 0");
  a_row_stays: assert property (@(posedge hclk) disable iff (!hresetn)
    mode == mode_otp && !ee_return |=> mode == mode_otp) else $error("row mode left");
  a_mode_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    flash_reset && mode == mode_ident |=> mode == mode_array) else $error("no array mode");
  a_ident_byte: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_fall && mode == mode_ident && fsel_any && special == SEL_IDENT && !any_busy
    |=> mcu_rdata == FLASH_IDENT) else $error("identifier byte wrong");
endmodule : flash_status_seq
`default_nettype wire

// *** sim/mcu_bus_model.sv ***
// behavioural microcontroller driving the parallel memory bus
`timescale 1ns/10ps
`default_nettype none
module mcu_bus_model
  import flash_status_pkg::*;
(
  input wire logic hclk,
  input wire logic [7:0] dq,
  output var mcu_pins_s pins
);
  localparam int HOLD = 6; // longer than the sync chain needs

  // bus idles with both strobes high and nothing selected
  initial begin
    pins = '0;
    pins.wr_n = 1'b1;
    pins.rd_n = 1'b1;
  end

  // one write strobe, address and data steady across it
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] fs,
                    input logic [3:0] es);
    @(posedge hclk);
    pins.addr <= a;
    pins.wdata <= d;
    pins.fsel <= fs;
    pins.esel <= es;
    repeat (2) @(posedge hclk);
    pins.wr_n <= 1'b0;
    repeat (HOLD) @(posedge hclk);
    pins.wr_n <= 1'b1;
    repeat (HOLD) @(posedge hclk);
    pins.wdata <= ~d; // released data keeps no stale value
    pins.fsel <= '0;
    pins.esel <= '0;
  endtask : wr

  // one read strobe, byte taken while the strobe is still low
  task automatic rd(input logic [15:0] a, input logic [7:0] fs, input logic [3:0] es,
                    output logic [7:0] d);
    @(posedge hclk);
    pins.addr <= a;
    pins.fsel <= fs;
    pins.esel <= es;
    repeat (2) @(posedge hclk);
    pins.rd_n <= 1'b0;
    repeat (HOLD + 3) @(posedge hclk);
    d = dq;
    pins.rd_n <= 1'b1;
    repeat (HOLD) @(posedge hclk);
    pins.addr <= ~a;
    pins.fsel <= '0;
    pins.esel <= '0;
  endtask : rd
endmodule : mcu_bus_model
`default_nettype wire

// *** sim/tb_flash_eeprom_read_status.sv ***
// self-checking bench for the flash read and status sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_flash_eeprom_read_status
  import flash_status_pkg::*;
();
  localparam logic [7:0] IDENT = 8'h5a; // value is arbitrary
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic prog_busy = 1'b0;
  logic erase_busy = 1'b0;
  logic ee_busy = 1'b0;
  logic busy_data7 = 1'b0;
  logic op_fail = 1'b0;
  logic hreadyout, hresp, mcu_rdata_oe, mem_otp;
  logic [31:0] hrdata, w;
  logic [7:0] mcu_rdata, mem_rdata, r1, r2;
  logic [15:0] mem_addr;
  mcu_pins_s pins;
  op_req_s op_req;
  int err_count = 0;
  int total_checks = 0;
  int prog_reqs = 0;
  int erase_reqs = 0;
  int ee_reqs = 0;
  int oe_cycles = 0;

  // array stand-in: row bytes carry a marker, array bytes a fixed mask
  assign mem_rdata = mem_otp ? {2'b01, mem_addr[5:0]} : (mem_addr[7:0] ^ 8'h3c);

  flash_status_seq #(.FLASH_IDENT(IDENT)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .mcu_in(pins), .mcu_rdata(mcu_rdata), .mcu_rdata_oe(mcu_rdata_oe), .mem_addr(mem_addr),
    .mem_otp(mem_otp), .mem_rdata(mem_rdata), .op_req(op_req), .prog_busy(prog_busy),
    .erase_busy(erase_busy), .ee_busy(ee_busy), .busy_data7(busy_data7), .op_fail(op_fail));

  mcu_bus_model mcu (.hclk(hclk), .dq(mcu_rdata), .pins(pins));

  // request pulses are one cycle wide, so they are counted as they pass
  always @(posedge hclk) begin
    if (op_req.prog) begin
      prog_reqs++;
    end
    if (op_req.erase) begin
      erase_reqs++;
    end
    if (op_req.ee_write) begin
      ee_reqs++;
    end
    if (mcu_rdata_oe) begin
      oe_cycles++;
    end
  end

  // free-running 25 MHz clock
  initial begin
    forever #20 hclk = ~hclk;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // single word transfer; waits on hready, never on a fixed count
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : ahb

  task automatic regchk(input string n, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    ahb(1'b0, a, 32'h0, w);
    chk(n, e, w & m);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : regchk

  task automatic pinchk(input string n, input logic [15:0] a, input logic [7:0] fs,
                        input logic [3:0] es, input logic [7:0] m, input logic [7:0] e);
    int oe_before;
    oe_before = oe_cycles;
    mcu.rd(a, fs, es, r1);
    chk(n, {24'h0, e}, {24'h0, r1 & m});
    chk("rdata_oe", 32'h1, {31'h0, oe_cycles != oe_before});
  endtask : pinchk

  // coded cycles carry junk in the ignored top address bits
  task automatic cmd(input logic [7:0] c, input logic [15:0] a, input logic [7:0] fs,
                     input logic [3:0] es);
    mcu.wr(16'h3555, CODE_DATA1, fs, es);
    mcu.wr(16'h7aaa, CODE_DATA2, fs, es);
    mcu.wr(a, c, fs, es);
  endtask : cmd

  task automatic t_regs();
    regchk("flash_prot_rst", OFS_FLASH_PROT, 32'hffffffff, {24'h0, FLASH_PROT_RST});
    regchk("ee_prot_rst", OFS_EE_PROT, 32'hffffffff, {28'h0, EE_PROT_RST});
    ahb(1'b1, OFS_FLASH_PROT, 32'hffffff05, w);
    ahb(1'b1, OFS_EE_PROT, 32'hffffffff, w);
    ahb(1'b1, OFS_STATUS, 32'hffffffff, w);
    ahb(1'b1, 8'h0c, 32'hffffffff, w);
    regchk("flash_prot", OFS_FLASH_PROT, 32'hffffffff, 32'h05);
    regchk("ee_prot", OFS_EE_PROT, 32'hffffffff, 32'h0f);
    regchk("status_ro", OFS_STATUS, 32'hffffffff, 32'h0);
    regchk("unmapped", 8'h0c, 32'hffffffff, 32'h0);
  endtask : t_regs

  task automatic t_ident();
    pinchk("flash_plain", 16'h1234, 8'h01, 4'h0, 8'hff, 8'h08);
    pinchk("ee_plain", 16'h0042, 8'h00, 4'h2, 8'hff, 8'h7e);
    cmd(CMD_READ_IDENT, 16'h0555, 8'h01, 4'h0);
    regchk("mode_ident", OFS_STATUS, 32'h3, 32'h1);
    pinchk("ident", 16'h0001, 8'h01, 4'h0, 8'hff, IDENT);
    pinchk("prot_yes", 16'h0002, 8'h01, 4'h0, 8'hff, PROT_YES);
    pinchk("prot_no", 16'h1082, 8'h02, 4'h0, 8'hff, PROT_NO);
    cmd(CMD_FLASH_RESET, 16'h0555, 8'h01, 4'h0);
    pinchk("array_back", 16'h0001, 8'h01, 4'h0, 8'hff, 8'h3d);
  endtask : t_ident

  task automatic t_otp();
    cmd(CMD_OTP_READ, 16'h0555, 8'h00, 4'h1);
    regchk("mode_row", OFS_STATUS, 32'h3, 32'h2);
    pinchk("row_first", 16'h0000, 8'h00, 4'h1, 8'hff, 8'h40);
    pinchk("row_last", 16'h803f, 8'h00, 4'h8, 8'hff, 8'h7f);
    cmd(CMD_EE_RETURN, 16'h0555, 8'h00, 4'h1);
    pinchk("row_left", 16'h003f, 8'h00, 4'h1, 8'hff, 8'h03);
  endtask : t_otp

  // sector 0 is protected and drops the program; sector 1 takes it
  // bit 7 of the programmed byte is 1, so polling must show 0
  task automatic t_prog();
    cmd(CMD_PROGRAM, 16'h0555, 8'h01, 4'h0);
    mcu.wr(16'h0010, 8'h80, 8'h01, 4'h0);
    chk("prog_blocked", 32'h0, prog_reqs);
    cmd(CMD_PROGRAM, 16'h0555, 8'h02, 4'h0);
    mcu.wr(16'h0010, 8'h80, 8'h02, 4'h0);
    chk("prog_req", 32'h1, prog_reqs);
    chk("prog_word", {8'h0, 16'h0010, 8'h80}, {8'h0, op_req.addr, op_req.data});
    prog_busy <= 1'b1;
    busy_data7 <= 1'b1;
    mcu.rd(16'h0010, 8'h02, 4'h0, r1);
    mcu.rd(16'h0010, 8'h02, 4'h0, r2);
    chk("poll_prog", 32'h0, {31'h0, r1[POLL_BIT]});
    chk("toggle", 32'h1, {31'h0, r1[TOGGLE_BIT] ^ r2[TOGGLE_BIT]});
    prog_busy <= 1'b0;
    mcu.rd(16'h0010, 8'h02, 4'h0, r1);
    mcu.rd(16'h0010, 8'h02, 4'h0, r2);
    chk("settled", {24'h0, r1}, {24'h0, r2});
    chk("prog_data", 32'h2c, {24'h0, r2});
    mcu.wr(16'h0100, 8'h00, 8'h00, 4'h1);
    chk("ee_req", 32'h1, ee_reqs);
    ee_busy <= 1'b1;
    busy_data7 <= 1'b0;
    pinchk("poll_ee", 16'h0100, 8'h00, 4'h1, 8'h80, 8'h80);
    ee_busy <= 1'b0;
    pinchk("ee_done", 16'h0100, 8'h00, 4'h1, 8'hff, 8'h3c);
  endtask : t_prog

  task automatic t_erase();
    cmd(CMD_ERASE_SETUP, 16'h0555, 8'h02, 4'h0);
    cmd(CMD_SECTOR_ERASE, 16'h2000, 8'h02, 4'h0);
    chk("erase_req", 32'h1, erase_reqs);
    regchk("window_open", OFS_STATUS, 32'h40, 32'h40);
    erase_busy <= 1'b1;
    pinchk("erase_poll", 16'h2000, 8'h02, 4'h0, 8'h88, 8'h00);
    op_fail <= 1'b1;
    @(posedge hclk);
    op_fail <= 1'b0;
    pinchk("err_pin", 16'h2000, 8'h02, 4'h0, 8'h20, 8'h20);
    repeat (ERASE_WIN_CYC) @(posedge hclk);
    pinchk("window_shut", 16'h2000, 8'h02, 4'h0, 8'h08, 8'h08);
    erase_busy <= 1'b0;
    regchk("err_reg", OFS_STATUS, 32'h20, 32'h20);
    // the failed sector is left alone from here on
    cmd(CMD_FLASH_RESET, 16'h0555, 8'h01, 4'h0);
    regchk("err_clear", OFS_STATUS, 32'h20, 32'h0);
  endtask : t_erase

  // only a protected sector named: no erase, a short busy spell, then array data
  task automatic t_prot_erase();
    cmd(CMD_ERASE_SETUP, 16'h0555, 8'h04, 4'h0);
    cmd(CMD_SECTOR_ERASE, 16'h2000, 8'h04, 4'h0);
    chk("erase_blocked", 32'h1, erase_reqs);
    mcu.rd(16'h2000, 8'h04, 4'h0, r1);
    mcu.rd(16'h2000, 8'h04, 4'h0, r2);
    chk("prot_poll", 32'h0, {31'h0, r1[POLL_BIT]});
    chk("prot_toggle", 32'h1, {31'h0, r1[TOGGLE_BIT] ^ r2[TOGGLE_BIT]});
    repeat (PROT_ERASE_CYC) @(posedge hclk);
    pinchk("prot_done", 16'h2000, 8'h04, 4'h0, 8'hff, 8'h3c);
  endtask : t_prot_erase

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  // main sequence; pins wait out the input synchroniser after reset
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    t_regs();
    t_ident();
    t_otp();
    t_prog();
    t_erase();
    t_prot_erase();
    print_verdict();
  end

  // watchdog: the full run needs well under a third of this span
  initial begin
    repeat (30000) @(posedge hclk);
    err_count++;
    print_verdict();
  end
endmodule : tb_flash_eeprom_read_status
`default_nettype wire
